/* File: rtl/timer_counter_core.sv */
// 16-bit modulo timer core with prescaler and avalon-mm register slave
`include "timer_params.svh"
`timescale 1ns/1ps
`default_nettype none
module timer_counter_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// avalon-mm slave
	input wire logic [`ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [`DATA_W-1:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output var logic [`DATA_W-1:0] avs_readdata,
	output var logic avs_waitrequest,
	// system state
	input wire logic break_active,
	input wire logic break_clear_permit,
	input wire logic wait_mode,
	// external clock pin
	input wire logic ext_timer_clock_pin,
	output var logic ext_clock_pin_input,
	// channel logic
	input wire logic [1:0] channel_event_flag,
	input wire logic [1:0] channel_irq_enable,
	output var logic [1:0] channel_irq_req,
	output var timer_pkg::count_t counter_value,
	output var logic overflow_tick,
	// processor requests
	output var logic overflow_irq_req,
	output var logic wake_req
);
	import timer_pkg::*;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	bus_state_t bus_state_reg;
	logic waitrequest_reg;
	logic [`DATA_W-1:0] readdata_reg;
	byte_t snap_low_reg;
	byte_t read_byte;
	logic req;
	logic accept;
	logic acc_rd;
	logic acc_wr;
	logic sel_ctrl;
	logic sel_cnt_hi;
	logic sel_cnt_lo;
	logic sel_mod_hi;
	logic sel_mod_lo;
	logic protect;

	logic flag_reg;
	logic irq_en_reg;
	logic halt_reg;
	prescale_t ps_reg;
	logic arm_reg;
	count_t cnt_reg;
	count_t mod_reg;
	logic mod_inhibit_reg;
	logic [5:0] pre_cnt_reg;
	logic [5:0] pre_mask;
	logic latched_reg;
	byte_t low_buf_reg;
	count_t cnt_step;
	logic run;
	logic tick;
	logic wrap;
	logic ovf_event;
	logic clr_hit;
	logic clear_ok;

	logic ext_s1_reg;
	logic ext_s2_reg;
	logic ext_s3_reg;
	logic ext_stable_reg;
	logic ext_rise;

	logic ovf_irq_reg;
	logic [1:0] ch_irq_reg;
	logic wake_reg;
	logic ext_input_reg;
	logic ovf_tick_reg;

	// bus decode; a request is taken on the edge where waitrequest is low
	assign req = avs_read | avs_write;
	assign accept = (bus_state_reg == bus_answer) && req;
	assign acc_rd = accept && avs_read;
	assign acc_wr = accept && avs_write && avs_byteenable[0];
	assign sel_ctrl = (avs_address == `ADDR_CTRL);
	assign sel_cnt_hi = (avs_address == `ADDR_CNT_HI);
	assign sel_cnt_lo = (avs_address == `ADDR_CNT_LO);
	assign sel_mod_hi = (avs_address == `ADDR_MOD_HI);
	assign sel_mod_lo = (avs_address == `ADDR_MOD_LO);
	assign protect = break_active && !break_clear_permit;

	// registers are out of reach in wait mode, so requests just stall
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bus_state_reg <= bus_idle;
			waitrequest_reg <= 1'b1;
		end
		else
		begin
			unique case (bus_state_reg)
				bus_idle:
				begin
					if (req && !wait_mode)
					begin
						bus_state_reg <= bus_answer;
						waitrequest_reg <= 1'b0;
					end
				end
				bus_answer:
				begin
					bus_state_reg <= bus_idle;
					waitrequest_reg <= 1'b1;
				end
			endcase
		end
	end

	always_comb
	begin
		read_byte = `BYTE_ZERO;
		if (sel_ctrl)
		begin
			read_byte[`FLAG_BIT] = flag_reg;
			read_byte[`IRQ_EN_BIT] = irq_en_reg;
			read_byte[`HALT_BIT] = halt_reg;
			read_byte[`PS_MSB:`PS_LSB] = ps_reg;
		end
		else if (sel_cnt_hi)
			read_byte = cnt_reg[`HI_MSB:`HI_LSB];
		else if (sel_cnt_lo)
			read_byte = latched_reg ? low_buf_reg : cnt_reg[`LO_MSB:`LO_LSB];
		else if (sel_mod_hi)
			read_byte = mod_reg[`HI_MSB:`HI_LSB];
		else if (sel_mod_lo)
			read_byte = mod_reg[`LO_MSB:`LO_LSB];
	end

	// read data and the low-byte snapshot are taken together, so a latched
	// low byte pairs with the high byte of the read that latched it
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			readdata_reg <= {`BYTE_PAD, `BYTE_ZERO};
			snap_low_reg <= `BYTE_ZERO;
		end
		else if (bus_state_reg == bus_idle && req)
		begin
			readdata_reg <= {`BYTE_PAD, read_byte};
			snap_low_reg <= cnt_reg[`LO_MSB:`LO_LSB];
		end
	end

	// external clock: three stages, a rising edge counts once stages two and
	// three agree
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
			ext_stable_reg <= 1'b0;
		end
		else
		begin
			ext_s1_reg <= ext_timer_clock_pin;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
			if (ext_s2_reg == ext_s3_reg)
				ext_stable_reg <= ext_s3_reg;
		end
	end
	assign ext_rise = (ext_s2_reg == ext_s3_reg) && ext_s3_reg &&
		!ext_stable_reg;

	// counting engine
	assign run = !halt_reg && !break_active;
	assign clr_hit = acc_wr && sel_ctrl && avs_writedata[`CLEAR_BIT];
	assign pre_mask = 6'((`MASK_ONE << ps_reg) - `MASK_ONE);
	assign tick = run && !clr_hit && ((ps_reg == `PS_EXT) ? ext_rise :
		((pre_cnt_reg & pre_mask) == pre_mask));
	assign cnt_step = (cnt_reg == mod_reg) ? `CNT_RESET :
		16'(cnt_reg + `CNT_ONE);
	assign wrap = tick && (cnt_step == mod_reg);
	assign ovf_event = wrap && !mod_inhibit_reg;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pre_cnt_reg <= `PRE_RESET;
		else if (clr_hit)
			pre_cnt_reg <= `PRE_RESET;
		else if (run)
			pre_cnt_reg <= 6'(pre_cnt_reg + `PRE_ONE);
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_reg <= `CNT_RESET;
		else if (clr_hit)
			cnt_reg <= `CNT_RESET;
		else if (tick)
			cnt_reg <= cnt_step;
	end

	// control bits; the clear bit has no storage and reads as zero
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_en_reg <= 1'b0;
			halt_reg <= `HALT_RESET;
			ps_reg <= `PS_RESET;
		end
		else if (acc_wr && sel_ctrl)
		begin
			irq_en_reg <= avs_writedata[`IRQ_EN_BIT];
			halt_reg <= avs_writedata[`HALT_BIT];
			ps_reg <= avs_writedata[`PS_MSB:`PS_LSB];
		end
	end

	// two-step flag clear; a protected break access neither arms nor
	// clears, but an arm made before the break survives it
	assign clear_ok = acc_wr && sel_ctrl && !avs_writedata[`FLAG_BIT] &&
		arm_reg && !protect;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			arm_reg <= 1'b0;
		else if (ovf_event || clear_ok)
			arm_reg <= 1'b0;
		else if (acc_rd && sel_ctrl && readdata_reg[`FLAG_BIT] && !protect)
			arm_reg <= 1'b1;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			flag_reg <= 1'b0;
		else if (ovf_event)
			flag_reg <= 1'b1;
		else if (clear_ok)
			flag_reg <= 1'b0;
	end

	// counter read latch
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			latched_reg <= 1'b0;
			low_buf_reg <= `BYTE_ZERO;
		end
		else if (acc_rd && sel_cnt_lo)
			latched_reg <= 1'b0;
		else if (acc_rd && sel_cnt_hi && !latched_reg)
		begin
			latched_reg <= 1'b1;
			low_buf_reg <= snap_low_reg;
		end
	end

	// modulo pair; the high byte takes effect at once, the inhibit masks the flag
	// set and the arm clear, not the wrap, on a match against a half-written value
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mod_reg <= `MOD_RESET;
			mod_inhibit_reg <= 1'b0;
		end
		else if (acc_wr && sel_mod_hi)
		begin
			mod_reg[`HI_MSB:`HI_LSB] <= avs_writedata[`LO_MSB:`LO_LSB];
			mod_inhibit_reg <= 1'b1;
		end
		else if (acc_wr && sel_mod_lo)
		begin
			mod_reg[`LO_MSB:`LO_LSB] <= avs_writedata[`LO_MSB:`LO_LSB];
			mod_inhibit_reg <= 1'b0;
		end
	end

	// registered outputs
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ovf_irq_reg <= 1'b0;
			ch_irq_reg <= 2'b00;
			wake_reg <= 1'b0;
			ext_input_reg <= 1'b0;
			ovf_tick_reg <= 1'b0;
		end
		else
		begin
			ovf_irq_reg <= flag_reg && irq_en_reg;
			ch_irq_reg <= channel_event_flag & channel_irq_enable;
			wake_reg <= wait_mode && ((flag_reg && irq_en_reg) ||
				(|(channel_event_flag & channel_irq_enable)));
			ext_input_reg <= (ps_reg == `PS_EXT);
			ovf_tick_reg <= wrap;
		end
	end

	assign avs_readdata = readdata_reg;
	assign avs_waitrequest = waitrequest_reg;
	assign overflow_irq_req = ovf_irq_reg;
	assign channel_irq_req = ch_irq_reg;
	assign wake_req = wake_reg;
	assign ext_clock_pin_input = ext_input_reg;
	assign overflow_tick = ovf_tick_reg;
	assign counter_value = cnt_reg;

	flag_set_a: assert property (ovf_event |=> flag_reg)
		else $error("overflow did not set flag");
	wrap_zero_a: assert property (tick && cnt_reg == mod_reg |=>
		cnt_reg == `CNT_RESET)
		else $error("counter did not wrap to zero");
	flag_cause_a: assert property ($rose(flag_reg) |-> $past(ovf_event))
		else $error("flag rose without overflow");
	irq_gate_a: assert property ($past(!irq_en_reg) |-> !overflow_irq_req)
		else $error("overflow request while disabled");
	irq_level_a: assert property (flag_reg && irq_en_reg ##1
		flag_reg && irq_en_reg |-> overflow_irq_req)
		else $error("overflow request not held");
	ch_gate_a: assert property (channel_irq_req[0] |->
		$past(channel_irq_enable[0]))
		else $error("channel request while disabled");
	halt_hold_a: assert property (halt_reg && !clr_hit |=>
		cnt_reg == $past(cnt_reg))
		else $error("counter moved while halted");
	clear_zero_a: assert property (clr_hit |=> cnt_reg == `CNT_RESET &&
		pre_cnt_reg == `PRE_RESET)
		else $error("clear did not zero counter");
	halt_clear_a: assert property (clr_hit && avs_writedata[`HALT_BIT] |=>
		cnt_reg == `CNT_RESET ##1 cnt_reg == `CNT_RESET)
		else $error("counter left zero after halt and clear");
	ext_select_a: assert property (ps_reg == `PS_EXT ##1 ps_reg == `PS_EXT
		|-> ext_clock_pin_input)
		else $error("pin not forced to input");
	latch_hold_a: assert property (latched_reg && !(acc_rd && sel_cnt_lo)
		|=> low_buf_reg == $past(low_buf_reg))
		else $error("latched low byte changed");
	mod_inhibit_a: assert property (mod_inhibit_reg |=> !$rose(flag_reg))
		else $error("overflow during modulo update");
	break_stop_a: assert property (break_active && !clr_hit |=>
		cnt_reg == $past(cnt_reg))
		else $error("counter moved during break");
	break_protect_a: assert property (protect |=> !$fell(flag_reg))
		else $error("status changed in protected break");

	overflow_c: cover property (ovf_event && irq_en_reg);
	flag_clear_c: cover property (clear_ok);
	latch_read_c: cover property (acc_rd && sel_cnt_hi ##[1:20]
		acc_rd && sel_cnt_lo);
	ext_tick_c: cover property (tick && ps_reg == `PS_EXT);
endmodule
`default_nettype wire

/* File: rtl/timer_params.svh */
// register map, field positions, reset values and widths of the timer core
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define ADDR_W 5
`define DATA_W 32
`define BYTE_PAD 24'h000000
`define ADDR_CTRL 5'h00
`define ADDR_CNT_HI 5'h04
`define ADDR_CNT_LO 5'h08
`define ADDR_MOD_HI 5'h0c
`define ADDR_MOD_LO 5'h10
`define FLAG_BIT 7
`define IRQ_EN_BIT 6
`define HALT_BIT 5
`define CLEAR_BIT 4
`define PS_MSB 2
`define PS_LSB 0
`define HI_MSB 15
`define HI_LSB 8
`define LO_MSB 7
`define LO_LSB 0
`define PS_EXT 3'h7
`define PS_RESET 3'h0
`define HALT_RESET 1'b1
`define CNT_RESET 16'h0000
`define CNT_ONE 16'h0001
`define MOD_RESET 16'hffff
`define BYTE_ZERO 8'h00
`define PRE_RESET 6'h00
`define PRE_ONE 6'h01
`define MASK_ONE 7'h01
`endif

/* File: rtl/timer_pkg.sv */
// types shared by the timer core
package timer_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [15:0] count_t;
	typedef logic [2:0] prescale_t;
	typedef enum logic {bus_idle, bus_answer} bus_state_t;
endpackage

/* File: verification/test_timer_counter_core.sv */
// self-checking bench for the timer core: bus reads, counting, flags, break
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"
`define CHK(nm, ex, got) \
	begin \
		samples_checked++; \
		if ((got) !== (ex)) \
		begin \
			error_cnt++; \
			$display("wrong value %s exp %h got %h", nm, ex, got); \
		end \
	end
module test_timer_counter_core;
	import timer_pkg::*;
	logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
	logic [`ADDR_W-1:0] avs_address;
	logic [`DATA_W-1:0] avs_writedata, avs_readdata;
	logic [3:0] avs_byteenable;
	logic break_active, break_clear_permit, wait_mode;
	logic ext_timer_clock_pin, ext_clock_pin_input;
	logic [1:0] channel_event_flag, channel_irq_enable, channel_irq_req;
	count_t counter_value;
	logic overflow_tick, overflow_irq_req, wake_req;
	int error_cnt, samples_checked, n, i, k;
	byte_t exp_q[$];
	byte_t exp_b;
	count_t c;
	logic [31:0] seed = 32'h2742;

	timer_counter_core dut (.ref_clk(ref_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .break_active(break_active),
		.break_clear_permit(break_clear_permit), .wait_mode(wait_mode),
		.ext_timer_clock_pin(ext_timer_clock_pin),
		.ext_clock_pin_input(ext_clock_pin_input),
		.channel_event_flag(channel_event_flag),
		.channel_irq_enable(channel_irq_enable),
		.channel_irq_req(channel_irq_req), .counter_value(counter_value),
		.overflow_tick(overflow_tick), .overflow_irq_req(overflow_irq_req),
		.wake_req(wake_req));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic give_verdict;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic timeout;
		error_cnt++;
		give_verdict();
	endtask

	// one avalon cycle; unused data and enable bits carry random noise
	task automatic bus(input logic wr, input logic [`ADDR_W-1:0] a,
		input byte_t d, input byte_t e);
		int w;
		@(posedge ref_clk);
		seed = lfsr(seed);
		avs_address <= a;
		avs_writedata <= {seed[23:0], d};
		avs_byteenable <= {seed[27:25], 1'b1};
		avs_read <= !wr;
		avs_write <= wr;
		if (!wr)
			exp_q.push_back(e);
		w = 0;
		do
		begin
			@(posedge ref_clk);
			w++;
		end
		while (avs_waitrequest !== 1'b0 && w < 100);
		if (w >= 100)
			timeout();
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [`ADDR_W-1:0] a, input byte_t d);
		bus(1'b1, a, d, `BYTE_ZERO);
	endtask

	task automatic rd(input logic [`ADDR_W-1:0] a, input byte_t e);
		bus(1'b0, a, `BYTE_ZERO, e);
	endtask

	// slow edges so the three-stage synchroniser sees every one
	task automatic pulse(input int p);
		repeat (p)
		begin
			@(posedge ref_clk);
			ext_timer_clock_pin <= 1'b1;
			repeat (4) @(posedge ref_clk);
			ext_timer_clock_pin <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		repeat (6) @(posedge ref_clk);
	endtask

	always @(posedge ref_clk)
	begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() != 0)
		begin
			exp_b = exp_q.pop_front();
			`CHK("readdata", {`BYTE_PAD, exp_b}, avs_readdata)
		end
	end

	initial
	begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial
	begin
		rst_n = 1'b0;
		{avs_read, avs_write, break_active, break_clear_permit} = 4'h0;
		{wait_mode, ext_timer_clock_pin} = 2'b00;
		avs_address = '0;
		avs_writedata = '0;
		avs_byteenable = 4'h0;
		channel_event_flag = 2'b00;
		channel_irq_enable = 2'b00;
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(`ADDR_CTRL, 8'h20);
		rd(`ADDR_CNT_HI, 8'h00);
		rd(`ADDR_CNT_LO, 8'h00);
		rd(`ADDR_MOD_HI, 8'hff);
		rd(`ADDR_MOD_LO, 8'hff);
		rd(5'h14, 8'h00);
		repeat (20) @(posedge ref_clk);
		`CHK("halted", `CNT_RESET, counter_value)
		wr(`ADDR_MOD_HI, 8'h00);
		wr(`ADDR_MOD_LO, 8'h05);
		wr(`ADDR_CTRL, 8'h40);
		n = 0;
		while (counter_value !== 16'h0005 && n < 100)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 100)
			timeout();
		`CHK("ovf_tick", 1'b1, overflow_tick)
		@(posedge ref_clk);
		#1;
		`CHK("wrap", `CNT_RESET, counter_value)
		`CHK("ovf_tick", 1'b0, overflow_tick)
		`CHK("ovf_irq", 1'b1, overflow_irq_req)
		rd(`ADDR_CTRL, 8'hc0);
		// cleared counter first, else it would run the long way round
		wr(`ADDR_CTRL, 8'h70);
		wr(`ADDR_MOD_LO, 8'h00);
		wr(`ADDR_CTRL, 8'h40);
		rd(`ADDR_CTRL, 8'hc0);
		wr(`ADDR_CTRL, 8'h40);
		rd(`ADDR_CTRL, 8'hc0);
		wr(`ADDR_MOD_HI, 8'h00);
		rd(`ADDR_CTRL, 8'hc0);
		wr(`ADDR_CTRL, 8'h40);
		rd(`ADDR_CTRL, 8'h40);
		`CHK("ovf_irq", 1'b0, overflow_irq_req)
		wr(`ADDR_MOD_LO, 8'h00);
		rd(`ADDR_CTRL, 8'hc0);
		wr(`ADDR_CTRL, 8'h60);
		rd(`ADDR_CTRL, 8'he0);
		wr(`ADDR_CTRL, 8'h60);
		rd(`ADDR_CTRL, 8'h60);
		wr(`ADDR_CTRL, 8'he0);
		rd(`ADDR_CTRL, 8'h60);
		wr(`ADDR_CTRL, 8'h40);
		wr(`ADDR_CTRL, 8'h60);
		break_active <= 1'b1;
		rd(`ADDR_CTRL, 8'he0);
		wr(`ADDR_CTRL, 8'h60);
		rd(`ADDR_CTRL, 8'he0);
		break_active <= 1'b0;
		rd(`ADDR_CTRL, 8'he0);
		break_active <= 1'b1;
		wr(`ADDR_CTRL, 8'h60);
		rd(`ADDR_CTRL, 8'he0);
		break_active <= 1'b0;
		wr(`ADDR_CTRL, 8'h60);
		rd(`ADDR_CTRL, 8'h60);
		wr(`ADDR_CTRL, 8'h40);
		wr(`ADDR_CTRL, 8'h60);
		break_active <= 1'b1;
		break_clear_permit <= 1'b1;
		rd(`ADDR_CTRL, 8'he0);
		wr(`ADDR_CTRL, 8'h60);
		break_active <= 1'b0;
		rd(`ADDR_CTRL, 8'h60);
		wr(`ADDR_CTRL, 8'h30);
		wr(`ADDR_MOD_HI, 8'hff);
		wr(`ADDR_MOD_LO, 8'hff);
		break_active <= 1'b1;
		wr(`ADDR_CTRL, 8'h00);
		repeat (10) @(posedge ref_clk);
		`CHK("in_break", `CNT_RESET, counter_value)
		break_active <= 1'b0;
		for (i = 0; i < 7; i++)
		begin
			wr(`ADDR_CTRL, byte_t'(16 + i));
			`CHK("pin_dir", 1'b0, ext_clock_pin_input)
			for (k = 0; k < 3; k++)
			begin
				c = counter_value;
				n = 0;
				while (counter_value === c && n < 300)
				begin
					@(posedge ref_clk);
					n++;
				end
				if (n >= 300)
					timeout();
			end
			`CHK("period", 1 << i, n)
		end
		wr(`ADDR_CTRL, 8'h30);
		repeat (8) @(posedge ref_clk);
		`CHK("clear", `CNT_RESET, counter_value)
		rd(`ADDR_CTRL, 8'h20);
		wr(`ADDR_CTRL, 8'h17);
		// select lands at the take edge, the pin flag one edge later
		repeat (2) @(posedge ref_clk);
		`CHK("pin_dir", 1'b1, ext_clock_pin_input)
		pulse(3);
		rd(`ADDR_CNT_HI, 8'h00);
		pulse(2);
		rd(`ADDR_CNT_HI, 8'h00);
		rd(`ADDR_CNT_LO, 8'h03);
		rd(`ADDR_CNT_LO, 8'h05);
		wr(`ADDR_CTRL, 8'h30);
		wr(`ADDR_MOD_HI, 8'h00);
		wr(`ADDR_MOD_LO, 8'h20);
		wr(`ADDR_CTRL, 8'h50);
		wait_mode <= 1'b1;
		n = 0;
		while (wake_req !== 1'b1 && n < 200)
		begin
			@(posedge ref_clk);
			#1;
			n++;
		end
		if (n >= 200)
			timeout();
		`CHK("wake", 1'b1, wake_req)
		// registers stay out of reach until wait mode ends
		fork
			rd(`ADDR_CTRL, 8'hc0);
			begin
				repeat (5) @(posedge ref_clk);
				`CHK("stall", 1'b1, avs_waitrequest)
				wait_mode <= 1'b0;
			end
		join
		for (i = 0; i < 32; i++)
		begin
			@(posedge ref_clk);
			seed = lfsr(seed);
			channel_event_flag <= seed[1:0];
			channel_irq_enable <= seed[3:2];
			@(posedge ref_clk);
			#1;
			`CHK("chan_irq", seed[1:0] & seed[3:2], channel_irq_req)
		end
		`CHK("pending", 0, exp_q.size())
		give_verdict();
	end
endmodule
`default_nettype wire
